/* File: core/dam_i2c_slave.v */
`timescale 1ns/1ns
`default_nettype none
`include "dam_defs.vh"
module dam_i2c_slave #(
    parameter [23:0] TWR_CYCLES = `DAM_TWR_CYC,
    parameter [7:0]  MAIN_DEFAULT = `DAM_MAIN_DEFAULT
) (
    input  wire        core_clk_i,
    input  wire        rstn_i,
    input  wire        scl_i,
    input  wire        sda_i,
    output wire        sda_o,
    output reg         sda_oe_n_o,
    input  wire        main_address_select_enable_i,
    input  wire [7:0]  main_dev_addr_i,
    input  wire        shadow_memory_mode_bit_i,
    output reg  [7:0]  rd_addr_o,
    output reg         rd_aux_o,
    input  wire [7:0]  rd_data_i,
    output wire        wr_valid_o,
    input  wire        wr_ready_i,
    output wire [7:0]  wr_addr_o,
    output wire [7:0]  wr_data_o,
    output wire        wr_aux_o,
    output wire        wr_shadow_o,
    output reg         prog_start_o,
    output reg         prog_aux_o,
    output reg  [4:0]  prog_row_o,
    output wire        prog_busy_o
);
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_ADDR = 2'h1;
    localparam [1:0] ST_RX   = 2'h2;
    localparam [1:0] ST_TX   = 2'h3;

    wire [1:0]  bus_s;
    wire        scl_s;
    wire        sda_s;
    reg         scl_d;
    reg         sda_d;
    wire        scl_rise;
    wire        scl_fall;
    wire        start_det;
    wire        stop_det;
    reg  [1:0]  state;
    reg  [3:0]  bitcnt;
    reg  [7:0]  shreg;
    reg  [7:0]  ptr;
    reg         first;
    reg         wrote;
    reg         master_nack;
    reg  [23:0] busy_cnt;
    reg         push;
    reg  [`DAM_WW_BITS-1:0] push_word;
    wire        push_ready;
    wire [`DAM_WW_BITS-1:0] buf_word;
    wire [6:0]  main_addr;
    wire        aux_hit;
    wire        main_hit;

    // ------------------------------------------------------------
    // pin sampling and bus conditions
    // ------------------------------------------------------------
    dam_sync #(
        .WIDTH (2)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .async_i    ({scl_i, sda_i}),
        .sync_o     (bus_s)
    );
    assign scl_s = bus_s[1];
    assign sda_s = bus_s[0];

    always @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_d;                      // [R4]
    assign scl_fall  = ~scl_s & scl_d;
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;      // [R1] [R3]
    assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;      // [R2]

    // ------------------------------------------------------------
    // address match
    // ------------------------------------------------------------
    assign main_addr = main_address_select_enable_i ?      // [R12]
                       main_dev_addr_i[7:1] : MAIN_DEFAULT[7:1]; // [R11]
    assign main_hit  = (shreg[7:1] == main_addr);
    assign aux_hit   = (shreg[7:1] == `DAM_AUX_ADDR) &     // [R10]
                       (main_addr != `DAM_AUX_ADDR);         // [R13]
    assign prog_busy_o = (busy_cnt != 24'h0);

    // open drain: only ever pulls low
    assign sda_o = 1'b0;

    // ------------------------------------------------------------
    // write path buffer
    // ------------------------------------------------------------
    dam_buf2 #(
        .WIDTH (`DAM_WW_BITS)
    ) u_buf (
        .core_clk_i  (core_clk_i),
        .rstn_i      (rstn_i),
        .in_valid_i  (push),
        .in_ready_o  (push_ready),
        .in_data_i   (push_word),
        .out_valid_o (wr_valid_o),
        .out_ready_i (wr_ready_i),
        .out_data_o  (buf_word)
    );
    assign wr_data_o   = buf_word[`DAM_WW_DATA_LSB+7:`DAM_WW_DATA_LSB];
    assign wr_addr_o   = buf_word[`DAM_WW_ADDR_LSB+7:`DAM_WW_ADDR_LSB];
    assign wr_shadow_o = buf_word[`DAM_WW_SHADOW];
    assign wr_aux_o    = buf_word[`DAM_WW_AUX];

    // ------------------------------------------------------------
    // protocol engine
    // ------------------------------------------------------------
    always @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state        <= ST_IDLE;
            bitcnt       <= 4'h0;
            shreg        <= 8'h00;
            ptr          <= 8'h00;
            first        <= 1'b0;
            wrote        <= 1'b0;
            master_nack  <= 1'b0;
            busy_cnt     <= 24'h0;
            push         <= 1'b0;
            push_word    <= {`DAM_WW_BITS{1'b0}};
            sda_oe_n_o   <= 1'b1;
            rd_addr_o    <= 8'h00;
            rd_aux_o     <= 1'b0;
            prog_start_o <= 1'b0;
            prog_aux_o   <= 1'b0;
            prog_row_o   <= 5'h00;
        end
        else
        begin
            push         <= 1'b0;
            prog_start_o <= 1'b0;
            rd_addr_o    <= ptr;
            if (busy_cnt != 24'h0)
                busy_cnt <= busy_cnt - 24'h1;
            if (start_det)
            begin
                state      <= ST_ADDR;                      // [R1] [R3]
                bitcnt     <= 4'h0;
                sda_oe_n_o <= 1'b1;
            end
            else if (stop_det)
            begin
                state      <= ST_IDLE;                      // [R2] [R18]
                sda_oe_n_o <= 1'b1;
                wrote      <= 1'b0;
                // shadow mode skips the program cycle when the last acked address was main
                if (wrote && (rd_aux_o || !shadow_memory_mode_bit_i))
                begin                                       // [R21] [R24]
                    busy_cnt     <= TWR_CYCLES;             // [R19]
                    prog_start_o <= 1'b1;                   // [R20]
                end
            end
            else if (state != ST_IDLE)
            begin
                if (scl_rise)
                begin
                    if (bitcnt < 4'h8 && state != ST_TX)
                        shreg <= {shreg[6:0], sda_s};       // [R7] [R4]
                    if (bitcnt == 4'h8 && state == ST_TX)
                        master_nack <= sda_s;               // [R6]
                    if (bitcnt != 4'h9)
                        bitcnt <= bitcnt + 4'h1;
                end
                else if (scl_fall)
                begin
                    case (state)
                    ST_ADDR:
                    begin
                        if (bitcnt == 4'h8)
                        begin
                            // busy device stays silent to allow polling
                            if ((main_hit || aux_hit) && !prog_busy_o)
                            begin                           // [R9] [R19]
                                sda_oe_n_o <= 1'b0;         // [R6]
                                rd_aux_o   <= aux_hit;
                            end
                            else
                                state <= ST_IDLE;           // [R14]
                        end
                        else if (bitcnt == 4'h9)
                        begin
                            bitcnt <= 4'h0;
                            first  <= 1'b1;
                            if (shreg[0])
                            begin                           // [R22] [R23]
                                state      <= ST_TX;
                                shreg      <= rd_data_i;
                                sda_oe_n_o <= rd_data_i[7]; // [R5]
                                ptr        <= ptr + 8'h01;  // [R25]
                            end
                            else
                            begin
                                state      <= ST_RX;
                                sda_oe_n_o <= 1'b1;
                            end
                        end
                    end
                    ST_RX:
                    begin
                        if (bitcnt == 4'h8)
                        begin
                            if (first)
                            begin
                                ptr        <= shreg;        // [R15] [R23]
                                sda_oe_n_o <= 1'b0;
                            end
                            else if (push_ready)
                            begin                           // [R16]
                                push       <= 1'b1;
                                push_word  <= {rd_aux_o,
                                    shadow_memory_mode_bit_i & ~rd_aux_o,
                                    ptr, shreg};
                                ptr        <= {ptr[7:`DAM_ROW_BITS],
                                    ptr[`DAM_ROW_BITS-1:0] + 3'h1}; // [R17]
                                // row latched here: a later read may move
                                // the counter or memory before the stop
                                prog_aux_o <= rd_aux_o;
                                prog_row_o <= ptr[7:`DAM_ROW_BITS];
                                wrote      <= 1'b1;
                                sda_oe_n_o <= 1'b0;
                            end
                            // full buffer: byte refused by not acknowledging
                        end
                        else if (bitcnt == 4'h9)
                        begin
                            bitcnt     <= 4'h0;
                            first      <= 1'b0;
                            sda_oe_n_o <= 1'b1;
                        end
                    end
                    ST_TX:
                    begin
                        if (bitcnt >= 4'h1 && bitcnt <= 4'h7)
                        begin
                            shreg      <= {shreg[6:0], 1'b0};
                            sda_oe_n_o <= shreg[6];         // [R5] [R7]
                        end
                        else if (bitcnt == 4'h8)
                            sda_oe_n_o <= 1'b1;             // [R6]
                        else if (bitcnt == 4'h9)
                        begin
                            bitcnt <= 4'h0;
                            if (master_nack)
                            begin
                                state      <= ST_IDLE;      // [R8]
                                sda_oe_n_o <= 1'b1;
                            end
                            else
                            begin
                                shreg      <= rd_data_i;
                                sda_oe_n_o <= rd_data_i[7];
                                ptr        <= ptr + 8'h01;  // [R25]
                            end
                        end
                    end
                    default:
                        state <= ST_IDLE;
                    endcase
                end
            end
        end
    end
endmodule // dam_i2c_slave
`default_nettype wire

/* File: core/dam_defs.vh */
// Behaviour
// R1 - sda falling while scl high starts transfer
// R2 - sda rising while scl high stops, idles
// R3 - repeated start behaves exactly like start
// R4 - sda changes while scl low, sampled rising
// R5 - device drives read bits after scl falls
// R6 - ninth bit acknowledges, low means ack
// R7 - eight data bits, msb first, then ack
// R8 - master nack ends read, sda released
// R9 - first byte: 7-bit address plus direction
// R10 - auxiliary memory answers fixed address a0h
// R11 - main address from configurable device byte
// R12 - configured main address needs select enable
// R13 - main address a0h disables auxiliary memory
// R14 - unmatched address: nack, ignore until start
// R15 - second write byte loads address counter
// R16 - one to eight data bytes, counter increments
// R17 - write counter wraps inside 8-byte row
// R18 - next row needs stop then new write
// R19 - no address ack while page programs
// R20 - page program keeps unwritten bytes intact
// R21 - shadow mode writes skip program cycle; code skips only when the last acked address was main
// R22 - read starts at current address counter
// R23 - dummy write then restart sets read address
// R24 - shadow mode locations act as plain ram
// R25 - read counter increments after each byte
`ifndef DAM_DEFS_VH
`define DAM_DEFS_VH

// ------------------------------------------------------------
// addresses
// ------------------------------------------------------------
`define DAM_AUX_ADDR      7'h50
`define DAM_MAIN_DEFAULT  8'ha2
`define DAM_ROW_BITS      3

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define DAM_CLK_NS        4
`define DAM_TWR_NS        10000000
`define DAM_TWR_CYC       ((`DAM_TWR_NS + `DAM_CLK_NS - 1) / `DAM_CLK_NS)

// ------------------------------------------------------------
// write word layout: {aux, shadow, addr, data}
// ------------------------------------------------------------
`define DAM_WW_DATA_LSB   0
`define DAM_WW_ADDR_LSB   8
`define DAM_WW_SHADOW     16
`define DAM_WW_AUX        17
`define DAM_WW_BITS       18

`endif

/* File: core/dam_sync.v */
`timescale 1ns/1ns
`default_nettype none
module dam_sync #(
    parameter WIDTH = 2
) (
    input  wire             core_clk_i,
    input  wire             rstn_i,
    input  wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    genvar g;
    // ------------------------------------------------------------
    // two flops per bit; idle bus level is high
    // ------------------------------------------------------------
    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : g_bit
            always @(posedge core_clk_i or negedge rstn_i)
            begin
                if (!rstn_i)
                begin
                    stage1[g] <= 1'b1;
                    stage2[g] <= 1'b1;
                end
                else
                begin
                    stage1[g] <= async_i[g];
                    stage2[g] <= stage1[g];
                end
            end
        end
    endgenerate
    assign sync_o = stage2;
endmodule // dam_sync
`default_nettype wire

/* File: core/dam_buf2.v */
`timescale 1ns/1ns
`default_nettype none
module dam_buf2 #(
    parameter WIDTH = 18
) (
    input  wire             core_clk_i,
    input  wire             rstn_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] slot0;
    reg [WIDTH-1:0] slot1;
    reg [1:0]       count;
    wire            push;
    wire            pop;
    assign in_ready_o  = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign out_data_o  = slot0;
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    // ------------------------------------------------------------
    // slot0 is the head; slot1 only holds while full
    // ------------------------------------------------------------
    always @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            slot0 <= {WIDTH{1'b0}};
            slot1 <= {WIDTH{1'b0}};
            count <= 2'h0;
        end
        else
        begin
            if (pop)
            begin
                slot0 <= (count == 2'h2) ? slot1 : in_data_i;
                if (count == 2'h1 && push)
                    slot0 <= in_data_i;
            end
            else if (push && count == 2'h0)
                slot0 <= in_data_i;
            if (push && ((count == 2'h1 && !pop) || (count == 2'h2)))
                slot1 <= in_data_i;
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // dam_buf2
`default_nettype wire

/* File: sim/dam_i2c_slave_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module dam_i2c_slave_checker #(
    parameter [23:0] TWR_CYCLES = 24'd600
) (
    input wire logic       core_clk_i,
    input wire logic       rstn_i,
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_n_o,
    input wire logic [7:0] rd_addr_o,
    input wire logic       wr_valid_o,
    input wire logic       wr_ready_i,
    input wire logic [7:0] wr_addr_o,
    input wire logic [7:0] wr_data_o,
    input wire logic       wr_aux_o,
    input wire logic       wr_shadow_o,
    input wire logic       prog_start_o,
    input wire logic       prog_aux_o,
    input wire logic [4:0] prog_row_o,
    input wire logic       prog_busy_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    logic        scl_q;
    logic        sda_q;
    logic [7:0]  since_stop;
    logic [23:0] busy_len;
    logic [8:0]  last_wr;
    wire         stop_seen = scl_q && scl_i && !sda_q && sda_i;
    // raw pins seen here, so stop timing is loose by the sync depth
    always_ff @(posedge core_clk_i or negedge rstn_i)
        if (!rstn_i)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            since_stop <= 8'hff;
            busy_len <= 24'h0;
            last_wr <= 9'h0;
        end
        else
        begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            if (stop_seen)
                since_stop <= 8'h00;
            else if (since_stop != 8'hff)
                since_stop <= since_stop + 8'h01;
            busy_len <= prog_busy_o ? busy_len + 24'h1 : 24'h0;
            if (wr_valid_o && wr_ready_i)
                last_wr <= {wr_aux_o, wr_addr_o};
        end
    a_open_drain: assert property (sda_o == 1'b0)
        else $error("sda value not zero");
    a_sda_scl_low: assert property ($changed(sda_oe_n_o) |-> !scl_i)
        else $error("sda moved while scl high");
    a_stop_idle: assert property (stop_seen |=> sda_oe_n_o [*8])
        else $error("sda pulled after stop");
    a_prog_stop: assert property (prog_start_o |-> since_stop <= 8'd8)
        else $error("program start without stop");
    a_prog_busy: assert property (
        prog_start_o |=> !prog_start_o ##[0:1] prog_busy_o)
        else $error("program start not followed by busy");
    a_busy_quiet: assert property (prog_busy_o |-> sda_oe_n_o)
        else $error("acknowledge while busy");
    a_busy_len: assert property (busy_len <= TWR_CYCLES + 24'd2 &&
        ($fell(prog_busy_o) -> busy_len >= TWR_CYCLES - 24'd2))
        else $error("busy length wrong");
    a_wr_hold: assert property (
        wr_valid_o && !wr_ready_i |=> wr_valid_o
        && $stable({wr_aux_o, wr_shadow_o, wr_addr_o, wr_data_o}))
        else $error("write word dropped or changed in stall");
    a_prog_row: assert property (prog_start_o && !wr_valid_o |->
        {prog_aux_o, prog_row_o} == {last_wr[8], last_wr[7:3]})
        else $error("programmed row differs from written row");
    a_shadow_main: assert property (
        wr_valid_o && wr_shadow_o |-> !wr_aux_o)
        else $error("shadow flag on auxiliary write");
    a_reset_state: assert property ($rose(rstn_i) |-> sda_oe_n_o
        && !prog_busy_o && !wr_valid_o && rd_addr_o == 8'h00)
        else $error("state after reset wrong");
endmodule // dam_i2c_slave_checker
bind dam_i2c_slave dam_i2c_slave_checker #(.TWR_CYCLES(TWR_CYCLES))
    dam_i2c_slave_checker_i (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .rd_addr_o(rd_addr_o), .wr_valid_o(wr_valid_o),
    .wr_ready_i(wr_ready_i), .wr_addr_o(wr_addr_o),
    .wr_data_o(wr_data_o), .wr_aux_o(wr_aux_o),
    .wr_shadow_o(wr_shadow_o), .prog_start_o(prog_start_o),
    .prog_aux_o(prog_aux_o), .prog_row_o(prog_row_o),
    .prog_busy_o(prog_busy_o));
`default_nettype wire

/* File: sim/dam_mst.sv */
`timescale 1ns/1ns
`default_nettype none
module dam_mst (
    output logic      scl_o,
    output logic      sda_rel_o,
    input  wire logic sda_i
);
    // scl idles high between frames, 125 ns per bit
    initial
    begin
        scl_o = 1'b1;
        sda_rel_o = 1'b1;
    end
    task automatic bit_io(input logic b, output logic r);
        sda_rel_o = b;
        #32 scl_o = 1'b1;
        #31 r = sda_i;
        #31 scl_o = 1'b0;
        #31;
    endtask
    task automatic start();
        if (!scl_o)
        begin
            sda_rel_o = 1'b1;
            #32 scl_o = 1'b1;
            #31;
        end
        sda_rel_o = 1'b0;
        #62 scl_o = 1'b0;
        #31;
    endtask
    task automatic stop();
        sda_rel_o = 1'b0;
        #32 scl_o = 1'b1;
        #62 sda_rel_o = 1'b1;
        #250;
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, ack);
    endtask
    task automatic recv(input logic nak, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            b[i] = r;
        end
        bit_io(nak, r);
    endtask
endmodule // dam_mst
`default_nettype wire

/* File: sim/tb_dam_i2c_slave.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_dam_i2c_slave;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       sel = 1'b0;
    logic [7:0] dev = 8'ha2;
    logic       shadow = 1'b0;
    logic       ready = 1'b1;
    logic [7:0] mem [0:511];
    int         fail_count;
    int         check_count;
    int         prog_cnt;
    int         cyc;
    wire        scl;
    wire        m_rel;
    wire        sda_o;
    wire        oe_n;
    wire [7:0]  rd_addr;
    wire        rd_aux;
    wire        wr_valid;
    wire [7:0]  wr_addr;
    wire [7:0]  wr_data;
    wire        wr_aux;
    wire        prog_start;
    wire        prog_aux;
    wire [4:0]  prog_row;
    wire        prog_busy;
    // pull-up bus: anyone may pull low
    wire        sda = m_rel & (oe_n | sda_o);
    always #2 clk = ~clk;
    dam_i2c_slave #(.TWR_CYCLES(24'd600)) dam_i2c_slave_i (
        .core_clk_i(clk), .rstn_i(rstn), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n_o(oe_n),
        .main_address_select_enable_i(sel), .main_dev_addr_i(dev),
        .shadow_memory_mode_bit_i(shadow), .rd_addr_o(rd_addr),
        .rd_aux_o(rd_aux), .rd_data_i(mem[{rd_aux, rd_addr}]),
        .wr_valid_o(wr_valid), .wr_ready_i(ready), .wr_addr_o(wr_addr),
        .wr_data_o(wr_data), .wr_aux_o(wr_aux), .wr_shadow_o(),
        .prog_start_o(prog_start), .prog_aux_o(prog_aux),
        .prog_row_o(prog_row), .prog_busy_o(prog_busy));
    dam_mst dam_mst_i (.scl_o(scl), .sda_rel_o(m_rel), .sda_i(sda));
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (wr_valid === 1'b1 && ready)
            mem[{wr_aux, wr_addr}] <= wr_data;
        if (prog_start === 1'b1)
            prog_cnt <= prog_cnt + 1;
        if (cyc == 60000)
        begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (fail_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tx(input logic [7:0] b, input logic exp);
        logic a;
        dam_mst_i.send(b, a);
        check({7'h0, a}, {7'h0, exp});
    endtask
    task automatic rx(input logic nak, input logic [7:0] exp);
        logic [7:0] b;
        dam_mst_i.recv(nak, b);
        check(b, exp);
    endtask
    task automatic cfg(input logic s, input logic [7:0] d, input logic h);
        @(posedge clk);
        #1;
        sel = s;
        dev = d;
        shadow = h;
    endtask
    task automatic wait_prog();
        for (int n = 0; n < 1000 && prog_busy !== 1'b0; n++)
            @(posedge clk);
        #500;
    endtask
    task automatic s_wrap();
        int p;
        p = prog_cnt;
        dam_mst_i.start();
        tx(8'ha2, 1'b0);
        tx(8'h06, 1'b0);
        tx(8'h11, 1'b0);
        tx(8'h22, 1'b0);
        tx(8'h33, 1'b0);
        dam_mst_i.stop();
        check(8'(prog_cnt - p), 8'h01);
        check({2'h0, prog_aux, prog_row}, 8'h00);
        dam_mst_i.start();
        tx(8'ha2, 1'b1);
        dam_mst_i.stop();
        wait_prog();
        check(mem[9'h006], 8'h11);
        check(mem[9'h000], 8'h33);
        check(mem[9'h001], 8'h5d);
    endtask
    task automatic s_read();
        dam_mst_i.start();
        tx(8'ha2, 1'b0);
        tx(8'h06, 1'b0);
        dam_mst_i.start();
        tx(8'ha3, 1'b0);
        rx(1'b0, 8'h11);
        rx(1'b0, 8'h22);
        rx(1'b1, 8'h54);
        dam_mst_i.stop();
        dam_mst_i.start();
        tx(8'ha3, 1'b0);
        rx(1'b1, 8'h55);
        dam_mst_i.stop();
    endtask
    task automatic s_aux();
        dam_mst_i.start();
        tx(8'ha0, 1'b0);
        tx(8'h05, 1'b0);
        tx(8'h5a, 1'b0);
        dam_mst_i.stop();
        check({7'h0, prog_aux}, 8'h01);
        wait_prog();
        check(mem[9'h105], 8'h5a);
        cfg(1'b1, 8'ha0, 1'b0);
        dam_mst_i.start();
        tx(8'ha2, 1'b1);
        dam_mst_i.start();
        tx(8'ha0, 1'b0);
        tx(8'h05, 1'b0);
        dam_mst_i.start();
        tx(8'ha1, 1'b0);
        rx(1'b1, 8'h59);
        dam_mst_i.stop();
    endtask
    task automatic s_cfg();
        cfg(1'b0, 8'hbc, 1'b0);
        dam_mst_i.start();
        tx(8'hbc, 1'b1);
        cfg(1'b1, 8'hbc, 1'b0);
        dam_mst_i.start();
        tx(8'hbc, 1'b0);
        dam_mst_i.start();
        tx(8'ha0, 1'b0);
        dam_mst_i.start();
        tx(8'h90, 1'b1);
        tx(8'h00, 1'b1);
        dam_mst_i.stop();
        cfg(1'b0, 8'ha2, 1'b1);
    endtask
    task automatic s_shadow();
        int p;
        p = prog_cnt;
        dam_mst_i.start();
        tx(8'ha2, 1'b0);
        tx(8'h20, 1'b0);
        tx(8'h77, 1'b0);
        dam_mst_i.stop();
        dam_mst_i.start();
        tx(8'ha2, 1'b0);
        tx(8'h20, 1'b0);
        dam_mst_i.start();
        tx(8'ha3, 1'b0);
        rx(1'b1, 8'h77);
        dam_mst_i.stop();
        check(8'(prog_cnt - p), 8'h00);
        cfg(1'b0, 8'ha2, 1'b0);
    endtask
    task automatic s_stall();
        @(posedge clk);
        #1 ready = 1'b0;
        dam_mst_i.start();
        tx(8'ha2, 1'b0);
        tx(8'h10, 1'b0);
        tx(8'ha1, 1'b0);
        tx(8'hb2, 1'b0);
        tx(8'hc3, 1'b1);
        dam_mst_i.stop();
        @(posedge clk);
        #1 ready = 1'b1;
        wait_prog();
        check(mem[9'h010], 8'ha1);
        check(mem[9'h011], 8'hb2);
        check(mem[9'h012], 8'h4e);
    endtask
    initial
    begin
        for (int i = 0; i < 512; i++)
            mem[i] = i[7:0] ^ 8'h5c;
        repeat (8) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (4) @(posedge clk);
        s_wrap();
        s_read();
        s_aux();
        s_cfg();
        s_shadow();
        s_stall();
        report_and_stop();
    end
endmodule // tb_dam_i2c_slave
`default_nettype wire
